// ==== rtl/sfpfe_front_end.sv ====
// serial flash pin protocol front end: select, pause, protect, lanes
//
// Overview of operation
// - write-protect low and write-disable bit set: register writes refused
// - quad-enable set: write-protect pin level ignored for protection
// - quad mode: write-protect pin is data line 2, in and out
// - pause pin low suspends transfer while selected, clock may run
// - chip select high during pause resets the interface logic
// - pause starts at pause fall if clock low, else at clock low
// - pause does not abort internal write, program or erase work
// - while paused: output released, input and clock disregarded
// - pause ends at pause rise if clock low, else at clock low
// - quad-enable set: pause disabled, pin is data line 3
// - only clock modes 0 and 3 supported
// - single rate: sample on rising edges, drive from falling edges
// - cycles counted fall to fall; mode 0 starts at select fall
// - double rate: instruction on rises, then both edges
// - double rate: first address bit on first rise after instruction
// - double rate read: first output at fall ending last dummy cycle
// - chip select high: inputs ignored, outputs released
`timescale 1ns/1ps
`include "sfpfe_cfg.svh"
module sfpfe_front_end #(
	parameter logic [7:0] WRR_CODE = `SFPFE_WRR_CODE,
	parameter int TX_DEPTH = `SFPFE_TX_DEPTH
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic [3:0] io_i,
	output logic [3:0] io_o,
	output logic [3:0] io_oe,
	input wire logic quad_enable_bit,
	input wire logic status_write_disable_bit,
	input wire sfpfe_pkg::sfpfe_lanes_t cmd_lanes,
	input wire logic cmd_ddr,
	input wire logic cmd_read,
	input wire logic [3:0] cmd_in_bytes,
	input wire logic [4:0] cmd_dummy,
	output logic [7:0] rx_byte,
	output logic rx_instr,
	output logic rx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic selected,
	output logic paused,
	output logic reg_write_lock,
	output logic wrr_refused,
	output logic frame_end,
	output logic frame_aligned,
	output logic tx_underrun
);
	import sfpfe_pkg::*;

	// ==========================================================
	// pin sampling
	logic [`SFPFE_PIN_W-1:0] pin_lvl;
	logic [`SFPFE_PIN_W-1:0] pin_rise;
	logic [`SFPFE_PIN_W-1:0] pin_fall;

	sfpfe_pin_sync #(
		.W(`SFPFE_PIN_W),
		.RST(`SFPFE_PIN_RST)
	) u_sync (
		.clk(clk),
		.nrst(nrst),
		.pin({cs_n, io_i, sck}),
		.lvl_q(pin_lvl),
		.rise_q(pin_rise),
		.fall_q(pin_fall)
	);

	logic cs_hi;
	logic sck_lo;
	logic hold_pin;
	logic wp_pin;
	logic [3:0] io_lvl;
	logic paused_q;
	logic sck_r;
	logic sck_f;

	assign cs_hi = pin_lvl[`SFPFE_PIN_CS];
	assign sck_lo = !pin_lvl[`SFPFE_PIN_SCK];
	assign io_lvl = pin_lvl[`SFPFE_PIN_HOLD:`SFPFE_PIN_IO0];
	assign hold_pin = pin_lvl[`SFPFE_PIN_HOLD];
	assign wp_pin = pin_lvl[`SFPFE_PIN_WP];
	// clock edges count only while selected and not paused
	assign sck_r = pin_rise[`SFPFE_PIN_SCK] && !cs_hi && !paused_q;
	assign sck_f = pin_fall[`SFPFE_PIN_SCK] && !cs_hi && !paused_q;

	// ==========================================================
	// pause control
	// level test covers both cases: pin edge with clock low, or
	// pin already changed and clock now reaching low
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			paused_q <= 1'b0;
		end else if (cs_hi || quad_enable_bit) begin
			paused_q <= 1'b0;
		end else if (!paused_q && !hold_pin && sck_lo) begin
			paused_q <= 1'b1;
		end else if (paused_q && hold_pin && sck_lo) begin
			paused_q <= 1'b0;
		end
	end

	// ==========================================================
	// protocol sequencer
	sfpfe_state_t st_q;
	sfpfe_lanes_t lanes_q;
	logic ddr_q;
	logic read_q;
	logic [3:0] in_bytes_q;
	logic [4:0] dummy_q;
	logic [3:0] bit_q;
	logic [3:0] byte_q;
	logic [4:0] dcnt_q;
	logic skip_q;
	logic wait_q;
	logic [7:0] sh_q;
	logic [7:0] sh_d;
	logic [3:0] bit_d;
	logic take;
	logic byte_done;

	function automatic logic [3:0] lane_n(sfpfe_lanes_t l);
		unique case (l)
			SFPFE_LANE2: lane_n = 4'h2;
			SFPFE_LANE4: lane_n = 4'h4;
			default: lane_n = 4'h1;
		endcase
	endfunction

	// instruction on rises only; data on both edges in double rate
	assign take = (st_q == SFPFE_INSTR && sck_r) ||
		(st_q == SFPFE_INPUT &&
		(sck_r || (ddr_q && sck_f && !skip_q)));

	always_comb begin
		sh_d = {sh_q[6:0], io_lvl[0]};
		bit_d = bit_q + 4'h1;
		if (st_q == SFPFE_INPUT) begin
			unique case (lanes_q)
				SFPFE_LANE2: sh_d = {sh_q[5:0], io_lvl[1:0]};
				SFPFE_LANE4: sh_d = {sh_q[3:0], io_lvl};
				default: sh_d = {sh_q[6:0], io_lvl[0]};
			endcase
			bit_d = bit_q + lane_n(lanes_q);
		end
	end

	assign byte_done = take && (bit_d == `SFPFE_BYTE_BITS);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= SFPFE_IDLE;
			lanes_q <= SFPFE_LANE1;
			ddr_q <= 1'b0;
			read_q <= 1'b0;
			in_bytes_q <= 4'h0;
			dummy_q <= 5'h00;
			bit_q <= 4'h0;
			byte_q <= 4'h0;
			dcnt_q <= 5'h00;
			skip_q <= 1'b0;
			wait_q <= 1'b0;
			sh_q <= 8'h00;
		end else if (cs_hi) begin
			st_q <= SFPFE_IDLE;
			bit_q <= 4'h0;
			byte_q <= 4'h0;
			dcnt_q <= 5'h00;
			skip_q <= 1'b0;
			wait_q <= 1'b0;
		end else if (!paused_q) begin
			if (take) begin
				sh_q <= sh_d;
				bit_q <= byte_done ? 4'h0 : bit_d;
			end
			unique case (st_q)
				SFPFE_IDLE: begin
					// a start needs a fresh select fall
					if (pin_fall[`SFPFE_PIN_CS]) begin
						st_q <= SFPFE_INSTR;
					end
				end
				SFPFE_INSTR: begin
					if (byte_done) begin
						st_q <= SFPFE_DECODE;
						skip_q <= 1'b1;
						wait_q <= 1'b0;
					end
				end
				SFPFE_DECODE: begin
					// one cycle for the decoder to see the instruction
					wait_q <= 1'b1;
					if (sck_f) begin
						skip_q <= 1'b0;
					end
					if (wait_q) begin
						lanes_q <= cmd_lanes;
						ddr_q <= cmd_ddr;
						read_q <= cmd_read;
						in_bytes_q <= cmd_in_bytes;
						dummy_q <= cmd_dummy;
						byte_q <= 4'h0;
						dcnt_q <= 5'h00;
						st_q <= (cmd_read && cmd_in_bytes == 4'h0) ?
							SFPFE_DUMMY : SFPFE_INPUT;
					end
				end
				SFPFE_INPUT: begin
					// first fall after the instruction closes its cycle
					if (sck_f && skip_q) begin
						skip_q <= 1'b0;
					end
					if (byte_done) begin
						byte_q <= byte_q + 4'h1;
						if (read_q && byte_q + 4'h1 == in_bytes_q) begin
							st_q <= SFPFE_DUMMY;
							dcnt_q <= sck_f ? 5'h01 : 5'h00;
						end
					end
				end
				SFPFE_DUMMY: begin
					if (sck_f) begin
						if (dcnt_q == dummy_q) begin
							st_q <= SFPFE_OUTPUT;
						end else begin
							dcnt_q <= dcnt_q + 5'h01;
						end
					end
				end
				SFPFE_OUTPUT: begin
				end
			endcase
		end
	end

	// ==========================================================
	// receive path
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_byte <= 8'h00;
			rx_instr <= 1'b0;
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= byte_done && !cs_hi && !paused_q;
			if (byte_done) begin
				rx_byte <= sh_d;
				rx_instr <= st_q == SFPFE_INSTR;
			end
		end
	end

	// ==========================================================
	// register write protection
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_write_lock <= 1'b0;
			wrr_refused <= 1'b0;
		end else begin
			// quad mode turns the pin into data, so no protection
			reg_write_lock <= !quad_enable_bit && status_write_disable_bit &&
				!wp_pin;
			wrr_refused <= byte_done && st_q == SFPFE_INSTR && !cs_hi &&
				!paused_q && sh_d == WRR_CODE && reg_write_lock;
		end
	end

	// ==========================================================
	// transmit path
	logic [7:0] txf_data;
	logic txf_valid;
	logic txf_pop;
	logic [7:0] osh_q;
	logic [7:0] osh_d;
	logic [3:0] obit_q;
	logic [3:0] obit_d;
	logic out_first;
	logic out_step;
	logic out_load;
	logic drive_en;

	sfpfe_fifo #(
		.WIDTH(`SFPFE_TX_WIDTH),
		.DEPTH(TX_DEPTH)
	) u_txf (
		.clk(clk),
		.nrst(nrst),
		.in_data(tx_data),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.out_data(txf_data),
		.out_valid(txf_valid),
		.out_ready(txf_pop)
	);

	// first bit at the fall ending the last dummy cycle
	assign out_first = st_q == SFPFE_DUMMY && sck_f &&
		dcnt_q == dummy_q;
	// single rate moves on falls, double rate on every edge
	assign out_step = st_q == SFPFE_OUTPUT &&
		(sck_f || (ddr_q && sck_r));
	assign obit_d = obit_q + lane_n(lanes_q);
	assign out_load = out_first ||
		(out_step && obit_d == `SFPFE_BYTE_BITS);
	assign txf_pop = out_load && txf_valid;
	assign drive_en = (st_q == SFPFE_OUTPUT || out_first) && !cs_hi &&
		!paused_q;

	always_comb begin
		osh_d = osh_q;
		if (out_load) begin
			osh_d = txf_valid ? txf_data : `SFPFE_FILL_BYTE;
		end else if (out_step) begin
			unique case (lanes_q)
				SFPFE_LANE2: osh_d = {osh_q[5:0], 2'h0};
				SFPFE_LANE4: osh_d = {osh_q[3:0], 4'h0};
				default: osh_d = {osh_q[6:0], 1'b0};
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			osh_q <= 8'h00;
			obit_q <= 4'h0;
			tx_underrun <= 1'b0;
		end else begin
			tx_underrun <= out_load && !txf_valid;
			if (cs_hi) begin
				obit_q <= 4'h0;
			end else if (out_load) begin
				osh_q <= osh_d;
				obit_q <= 4'h0;
			end else if (out_step) begin
				osh_q <= osh_d;
				obit_q <= obit_d;
			end
		end
	end

	// pins: msb on the highest lane, oe high while driving
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			io_o <= 4'h0;
			io_oe <= 4'h0;
		end else begin
			unique case (lanes_q)
				SFPFE_LANE2: io_o <= {2'h0, osh_d[7:6]};
				SFPFE_LANE4: io_o <= osh_d[7:4];
				default: io_o <= {2'h0, osh_d[7], 1'b0};
			endcase
			if (!drive_en) begin
				io_oe <= 4'h0;
			end else begin
				unique case (lanes_q)
					SFPFE_LANE2: io_oe <= `SFPFE_OE_LANE2;
					SFPFE_LANE4: io_oe <= quad_enable_bit ?
						`SFPFE_OE_LANE4 : `SFPFE_OE_LANE2;
					default: io_oe <= `SFPFE_OE_LANE1;
				endcase
			end
		end
	end

	// ==========================================================
	// status
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			selected <= 1'b0;
			paused <= 1'b0;
			frame_end <= 1'b0;
			frame_aligned <= 1'b0;
		end else begin
			selected <= !cs_hi && st_q != SFPFE_IDLE;
			paused <= paused_q;
			frame_end <= pin_rise[`SFPFE_PIN_CS] && st_q != SFPFE_IDLE;
			if (pin_rise[`SFPFE_PIN_CS]) begin
				frame_aligned <= bit_q == 4'h0 && st_q != SFPFE_INSTR;
			end
		end
	end

endmodule

// ==== rtl/sfpfe_cfg.svh ====
// constants of the serial flash pin protocol front end
`ifndef SFPFE_CFG_SVH
`define SFPFE_CFG_SVH

// serial clock and pins
`define SFPFE_PIN_W 6
`define SFPFE_PIN_RST 6'h38
`define SFPFE_PIN_SCK 0
`define SFPFE_PIN_IO0 1
`define SFPFE_PIN_IO1 2
`define SFPFE_PIN_WP 3
`define SFPFE_PIN_HOLD 4
`define SFPFE_PIN_CS 5

// byte framing
`define SFPFE_BYTE_BITS 4'h8
`define SFPFE_FILL_BYTE 8'hff
`define SFPFE_WRR_CODE 8'h01

// lane masks for output enables
`define SFPFE_OE_LANE1 4'h2
`define SFPFE_OE_LANE2 4'h3
`define SFPFE_OE_LANE4 4'hf

// transmit buffer
`define SFPFE_TX_DEPTH 4
`define SFPFE_TX_WIDTH 8

`endif

// ==== rtl/sfpfe_pkg.sv ====
// types of the serial flash pin protocol front end
package sfpfe_pkg;

	typedef enum logic [1:0] {
		SFPFE_LANE1 = 2'h0,
		SFPFE_LANE2 = 2'h1,
		SFPFE_LANE4 = 2'h2
	} sfpfe_lanes_t;

	typedef enum logic [2:0] {
		SFPFE_IDLE,
		SFPFE_INSTR,
		SFPFE_DECODE,
		SFPFE_INPUT,
		SFPFE_DUMMY,
		SFPFE_OUTPUT
	} sfpfe_state_t;

endpackage

// ==== rtl/sfpfe_pin_sync.sv ====
// three-stage pin synchroniser with agreed level and edge pulses
`timescale 1ns/1ps
module sfpfe_pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] lvl_q,
	output logic [W-1:0] rise_q,
	output logic [W-1:0] fall_q
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] lvl_d;

	// a change counts once the second and third stages agree
	always_comb begin
		lvl_d = lvl_q;
		for (int i = 0; i < W; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				lvl_d[i] = s2_q[i];
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1_q <= RST;
			s2_q <= RST;
			s3_q <= RST;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lvl_q <= RST;
			rise_q <= '0;
			fall_q <= '0;
		end else begin
			lvl_q <= lvl_d;
			rise_q <= lvl_d & ~lvl_q;
			fall_q <= ~lvl_d & lvl_q;
		end
	end

endmodule

// ==== rtl/sfpfe_fifo.sv ====
// small first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
module sfpfe_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_q[rd_q];

	always_comb begin
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + CW'(1);
		end else if (pop && !push) begin
			cnt_d = cnt_q - CW'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
			end
			cnt_q <= cnt_d;
			in_ready <= cnt_d != CW'(DEPTH);
			out_valid <= cnt_d != '0;
		end
	end

endmodule

// ==== tb/sfpfe_checker.sv ====
// port assertions of the front end
`timescale 1ns/1ps
module sfpfe_checker (
	input wire logic clk,
	input wire logic nrst,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic [3:0] io_i,
	input wire logic [3:0] io_o,
	input wire logic [3:0] io_oe,
	input wire logic quad_enable_bit,
	input wire logic status_write_disable_bit,
	input wire logic cmd_ddr,
	input wire logic selected,
	input wire logic paused,
	input wire logic reg_write_lock
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// ====================
	// properties
	property p_lock;
		$stable({quad_enable_bit, status_write_disable_bit, io_i[2]})[*7]
			|-> reg_write_lock == (!quad_enable_bit
			&& status_write_disable_bit && !io_i[2]);
	endproperty
	a_lock: assert property (p_lock)
		else $error("register lock level wrong");
	property p_desel;
		cs_n [*7] |-> io_oe == 4'h0 && !paused;
	endproperty
	a_desel: assert property (p_desel)
		else $error("outputs driven while deselected");
	property p_hold_oe;
		paused [*3] |-> io_oe == 4'h0;
	endproperty
	a_hold_oe: assert property (p_hold_oe)
		else $error("outputs driven while paused");
	property p_qe;
		quad_enable_bit [*8] |-> !paused;
	endproperty
	a_qe: assert property (p_qe)
		else $error("pause taken in quad mode");
	property p_enter;
		(selected && !cs_n && !io_i[3] && !sck && !quad_enable_bit) [*8]
			|-> paused;
	endproperty
	a_enter: assert property (p_enter)
		else $error("pause not entered");
	property p_exit;
		(io_i[3] && !sck) [*8] |-> !paused;
	endproperty
	a_exit: assert property (p_exit)
		else $error("pause not left");
	property p_abort;
		$rose(cs_n) && paused |-> ##[1:6] (!paused && !selected);
	endproperty
	a_abort: assert property (p_abort)
		else $error("deselect in pause did not reset");
	property p_sdr;
		$changed(io_o) && io_oe != 4'h0 && $past(io_oe) != 4'h0 && !cmd_ddr
			|-> !$past(sck, 3);
	endproperty
	a_sdr: assert property (p_sdr)
		else $error("output changed away from a clock fall");
	c_pause: cover property (paused);
	c_abort: cover property ($rose(cs_n) && paused);
	c_quad: cover property (io_oe == 4'hf);
endmodule

bind sfpfe_front_end sfpfe_checker u_chk (
	.clk(clk), .nrst(nrst), .sck(sck), .cs_n(cs_n),
	.io_i(io_i), .io_o(io_o), .io_oe(io_oe),
	.quad_enable_bit(quad_enable_bit),
	.status_write_disable_bit(status_write_disable_bit),
	.cmd_ddr(cmd_ddr), .selected(selected), .paused(paused),
	.reg_write_lock(reg_write_lock)
);

// ==== tb/sfpfe_host_model.sv ====
// host spi master model driving the link pins
`timescale 1ns/1ps
module sfpfe_host_model (
	output logic sck,
	output logic cs_n,
	output logic sd,
	output logic hold,
	input wire logic [3:0] io_w
);
	localparam time HALF = 80ns;
	// ====================
	// idle levels, mode 0
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		sd = 1'b0;
		hold = 1'b1;
	end
	// ====================
	// frame tasks
	task automatic start();
		hold = 1'b1;
		#HALF cs_n = 1'b0;
	endtask
	task automatic put(input logic [7:0] v, input int n);
		for (int i = 7; i > 7 - n; i--) begin
			sd = v[i];
			#HALF sck = 1'b1;
			#HALF sck = 1'b0;
		end
	endtask
	task automatic get(output logic [7:0] v);
		for (int i = 7; i >= 0; i--) begin
			#HALF sck = 1'b1;
			v[i] = io_w[1];
			#HALF sck = 1'b0;
		end
	endtask
	// pause pin moved at clock low, clock and data keep moving
	task automatic pause(input logic v, input int n);
		hold = v;
		repeat (n) begin
			#HALF sck = 1'b1;
			sd = ~sd;
			#HALF sck = 1'b0;
		end
	endtask
	task automatic stop();
		#HALF cs_n = 1'b1;
	endtask
endmodule

// ==== tb/tb_sfpfe_front_end.sv ====
// bench of the serial flash pin protocol front end
`timescale 1ns/1ps
`include "sfpfe_cfg.svh"
module tb_sfpfe_front_end;
	import sfpfe_pkg::*;
	logic clk, nrst, sck, cs_n, sd, hold, wp, qe, swd, rd, tx_valid;
	logic [3:0] io_i, io_o, io_oe;
	logic [3:0] masks [3] = '{`SFPFE_OE_LANE1, `SFPFE_OE_LANE2, 4'hf};
	logic [7:0] rx_byte, tx_data, last_rx, b, got;
	logic rx_valid, tx_ready, selected, paused, lock, refused, seen;
	sfpfe_lanes_t lanes;
	logic [7:0] model_q [$];
	int errors, compares, seed;
	assign io_i = (io_oe & io_o) | (~io_oe & {hold, wp, ~io_o[1], sd});
	sfpfe_front_end u_dut (
		.clk(clk), .nrst(nrst), .sck(sck), .cs_n(cs_n), .io_i(io_i),
		.io_o(io_o), .io_oe(io_oe), .quad_enable_bit(qe),
		.status_write_disable_bit(swd), .cmd_lanes(lanes), .cmd_ddr(1'b0),
		.cmd_read(rd), .cmd_in_bytes(4'h0), .cmd_dummy(5'h00),
		.rx_byte(rx_byte), .rx_instr(), .rx_valid(rx_valid),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.selected(selected), .paused(paused), .reg_write_lock(lock),
		.wrr_refused(refused), .frame_end(), .frame_aligned(),
		.tx_underrun()
	);
	sfpfe_host_model u_host (
		.sck(sck), .cs_n(cs_n), .sd(sd), .hold(hold), .io_w(io_i)
	);
	// ====================
	// clock, monitor, checks
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (rx_valid) last_rx <= rx_byte;
		if (refused) seen <= 1'b1;
	end
	task automatic chk_byte(input logic [7:0] g, e);
		compares++;
		if (g !== e) begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_bit(input logic g, e);
		chk_byte({7'h00, g}, {7'h00, e});
	endtask
	task automatic cfg(input logic q, s, w, input sfpfe_lanes_t l,
			input logic r);
		@(negedge clk);
		qe = q;
		swd = s;
		wp = w;
		lanes = l;
		rd = r;
		seen = 1'b0;
		repeat (8) @(negedge clk);
	endtask
	task automatic wrap_up();
		if (errors == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		#300us;
		errors++;
		wrap_up();
	end
	// ====================
	// scenarios
	initial begin
		seed = 32'hbcd6;
		nrst = 1'b0;
		{wp, qe, swd, rd, tx_valid, seen} = 6'h20;
		tx_data = 8'h00;
		last_rx = 8'h00;
		lanes = SFPFE_LANE1;
		repeat (4) @(posedge clk);
		@(negedge clk);
		nrst = 1'b1;
		chk_bit(tx_ready, 1'b1);
		chk_bit(selected, 1'b0);
		repeat (8) @(negedge clk);
		// fill the buffer until it refuses
		repeat (6) begin
			@(negedge clk);
			tx_valid = 1'b1;
			tx_data = 8'($random(seed));
			@(posedge clk);
			if (tx_ready) model_q.push_back(tx_data);
		end
		@(negedge clk);
		tx_valid = 1'b0;
		chk_byte(8'(model_q.size()), 8'(`SFPFE_TX_DEPTH));
		// single lane read drains past empty
		b = 8'($random(seed));
		cfg(0, 0, 1, SFPFE_LANE1, 1);
		u_host.start();
		u_host.put(b, 8);
		repeat (5) begin
			u_host.get(got);
			chk_byte(got, model_q.size() ? model_q.pop_front() :
				`SFPFE_FILL_BYTE);
		end
		u_host.stop();
		chk_byte(last_rx, b);
		// register write under every protect combination
		for (int i = 0; i < 8; i++) begin
			cfg(i[2], i[1], i[0], SFPFE_LANE1, 0);
			u_host.start();
			u_host.put(`SFPFE_WRR_CODE, 8);
			u_host.stop();
			repeat (8) @(negedge clk);
			chk_bit(lock, !i[2] && i[1] && !i[0]);
			chk_bit(seen, !i[2] && i[1] && !i[0]);
		end
		// pause in mid instruction, clock and data toggling
		b = 8'($random(seed));
		cfg(0, 0, 1, SFPFE_LANE1, 0);
		u_host.start();
		u_host.put(b, 4);
		u_host.pause(1'b0, 2);
		chk_bit(paused, 1'b1);
		u_host.pause(1'b1, 0);
		repeat (7) @(negedge clk);
		chk_bit(paused, 1'b0);
		u_host.put(b << 4, 4);
		u_host.stop();
		repeat (8) @(negedge clk);
		chk_byte(last_rx, b);
		// deselect while paused, then a fresh command
		u_host.start();
		u_host.put(b, 3);
		u_host.pause(1'b0, 1);
		u_host.stop();
		repeat (8) @(negedge clk);
		chk_bit(paused, 1'b0);
		b = 8'($random(seed));
		u_host.start();
		u_host.put(b, 8);
		u_host.stop();
		repeat (8) @(negedge clk);
		chk_byte(last_rx, b);
		// quad mode: pause pin ignored
		cfg(1, 0, 1, SFPFE_LANE1, 0);
		u_host.start();
		u_host.put(b, 4);
		u_host.pause(1'b0, 0);
		repeat (8) @(negedge clk);
		chk_bit(paused, 1'b0);
		u_host.pause(1'b1, 0);
		u_host.put(b << 4, 4);
		u_host.stop();
		repeat (8) @(negedge clk);
		chk_byte(last_rx, b);
		// output lanes of each width
		for (int l = 0; l < 3; l++) begin
			cfg(1, 0, 1, sfpfe_lanes_t'(l), 1);
			u_host.start();
			u_host.put(b, 8);
			repeat (6) @(negedge clk);
			chk_byte({4'h0, io_oe}, {4'h0, masks[l]});
			u_host.get(got);
			u_host.stop();
		end
		repeat (8) @(negedge clk);
		wrap_up();
	end
endmodule
